// [verilog/t16c_timer.sv]
// three-channel 16-bit timer: counters, general registers, flags and contention
// assumes bus accesses arrive in step with clk_i, one state per cycle
// Notes on behaviour
// - counter clear in write state three wins; written value is dropped
// - word write in state three wins over increment; no count
// - byte write in state two or three blocks increment; other byte kept
// - general register write in state three suppresses its compare match
// - overflow during counter write: write wins, overflow flag still sets
// - read in state three returns general register value before capture
// - capture clear with increment: clear, no count, old count captured
// - capture during general register write wins; processor write dropped
// - compare clear happens at the count edge, period is N plus one
// - byte write to a synchronized counter presets all synchronized counters
// - clear_select 01 clears on source A, 10 on source B
// - clear_select 11 with sync enable clears with other synchronized channels
// - without PWM, A select bit chooses compare (0) or capture (1)
// - without PWM, B select bit chooses compare (0) or capture (1)
// - PWM mode disables input capture on the channel
// - PWM mode: simultaneous A and B matches suppress the compare signal
// - PWM mode: output high on match A, low on match B
// - overflow flag sets on wrap up from ffff or down from 0000
// - flag clears only after read while set, then write of zero
module t16c_timer #(
  parameter int NCH = `T16C_NCH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire t16c_pkg::t16c_acc_t acc_i,
  input wire t16c_pkg::t16c_flag_acc_t flag_acc_i,
  input wire t16c_pkg::t16c_cfg_t [NCH-1:0] cfg_i,
  input wire logic [NCH-1:0] count_pulse_i,
  input wire logic [NCH-1:0] capture_a_pin_i,
  input wire logic [NCH-1:0] capture_b_pin_i,
  output logic [NCH-1:0][15:0] timer_count_o,
  output logic [NCH-1:0][2:0] status_o,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  output logic [NCH-1:0] channel_a_pin_o,
  output logic [NCH-1:0] channel_a_pin_oe_o
);
  logic [NCH-1:0][15:0] timer_count, general_reg_a, general_reg_b;
  logic [NCH-1:0][2:0] status, armed;
  logic [NCH-1:0] sa1, sa2, sa3, sb1, sb2, sb3;
  logic [NCH-1:0] cnt_wr, byte_t2, gra_wr, grb_wr, cm_a, cm_b, cap_a, cap_b;
  logic [NCH-1:0] clr, wrap, own_clr;
  logic [NCH-1:0][15:0] next_count;
  logic sync_src, sync_wr, acc_t3;
  logic [15:0] sync_val;

  // merge a word or byte write into a register's old value
  function automatic logic [15:0] t16c_merge(input logic [15:0] old,
                                             input logic [15:0] wd,
                                             input logic [1:0] sz);
    logic [15:0] r;
    r = wd;
    if (sz == `T16C_SZ_HIGH) begin
      r = {wd[15:8], old[7:0]};
    end else if (sz == `T16C_SZ_LOW) begin
      r = {old[15:8], wd[7:0]};
    end
    return r;
  endfunction : t16c_merge

  // capture pins come from outside: two flops, then a third for edge detect
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sa1 <= '0;
      sa2 <= '0;
      sa3 <= '0;
      sb1 <= '0;
      sb2 <= '0;
      sb3 <= '0;
    end else begin
      sa1 <= capture_a_pin_i;
      sa2 <= sa1;
      sa3 <= sa2;
      sb1 <= capture_b_pin_i;
      sb2 <= sb1;
      sb3 <= sb2;
    end
  end

  assign acc_t3 = acc_i.valid && acc_i.tstate == `T16C_T3;

  // per-channel event decode; sources gathered for synchronous clearing
  always_comb begin
    sync_src = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      logic sel_c;
      sel_c = acc_i.valid && acc_i.write && acc_i.chan == 2'(c);
      cnt_wr[c] = sel_c && acc_t3 && acc_i.rsel == `T16C_SEL_CNT;
      byte_t2[c] = sel_c && acc_i.rsel == `T16C_SEL_CNT &&
                   acc_i.size != `T16C_SZ_WORD && acc_i.tstate == `T16C_T2;
      gra_wr[c] = sel_c && acc_t3 && acc_i.rsel == `T16C_SEL_GRA;
      grb_wr[c] = sel_c && acc_t3 && acc_i.rsel == `T16C_SEL_GRB;
      // match fires on the count edge leaving the equal value
      cm_a[c] = count_pulse_i[c] && timer_count[c] == general_reg_a[c] && !gra_wr[c];
      cm_b[c] = count_pulse_i[c] && timer_count[c] == general_reg_b[c] && !grb_wr[c];
      if (cfg_i[c].pwm_mode_bit && cm_a[c] && cm_b[c]) begin
        cm_a[c] = 1'b0;
        cm_b[c] = 1'b0;
      end
      cap_a[c] = sa2[c] && !sa3[c] && cfg_i[c].io_a_capture_select &&
                 !cfg_i[c].pwm_mode_bit;
      cap_b[c] = sb2[c] && !sb3[c] && cfg_i[c].io_b_capture_select &&
                 !cfg_i[c].pwm_mode_bit;
      if (cfg_i[c].io_a_capture_select && !cfg_i[c].pwm_mode_bit) begin
        cm_a[c] = 1'b0;
      end
      if (cfg_i[c].io_b_capture_select && !cfg_i[c].pwm_mode_bit) begin
        cm_b[c] = 1'b0;
      end
      own_clr[c] = (cfg_i[c].clear_select == `T16C_CLR_A && (cm_a[c] || cap_a[c])) ||
                   (cfg_i[c].clear_select == `T16C_CLR_B && (cm_b[c] || cap_b[c]));
      if (own_clr[c] && cfg_i[c].sync_enable_ch) begin
        sync_src = 1'b1;
      end
      wrap[c] = count_pulse_i[c] && (cfg_i[c].count_down ?
                timer_count[c] == `T16C_ZERO : timer_count[c] == `T16C_ALL1);
    end
    for (int c = 0; c < NCH; c++) begin
      clr[c] = own_clr[c] || (cfg_i[c].clear_select == `T16C_CLR_SYNC &&
               cfg_i[c].sync_enable_ch && sync_src);
    end
  end

  // value of the addressed counter after a write, shared by synchronized peers
  always_comb begin
    sync_val = t16c_merge(timer_count[acc_i.chan], acc_i.wdata, acc_i.size);
    sync_wr = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      if (cnt_wr[c] && cfg_i[c].sync_enable_ch) begin
        sync_wr = 1'b1;
      end
    end
  end

  // counter priority: clear, then write, then byte hold, then count
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      if (clr[c]) begin
        next_count[c] = `T16C_ZERO;
      end else if (cnt_wr[c]) begin
        next_count[c] = sync_val;
      end else if (sync_wr && cfg_i[c].sync_enable_ch) begin
        next_count[c] = sync_val;
      end else if (byte_t2[c]) begin
        next_count[c] = timer_count[c];
      end else if (count_pulse_i[c]) begin
        next_count[c] = cfg_i[c].count_down ? timer_count[c] - `T16C_ONE
                                            : timer_count[c] + `T16C_ONE;
      end else begin
        next_count[c] = timer_count[c];
      end
    end
  end

  // counters
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_count <= '0;
    end else begin
      timer_count <= next_count;
    end
  end

  // general registers: capture takes the pre-clear count and beats the write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      general_reg_a <= '1;
      general_reg_b <= '1;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (cap_a[c]) begin
          general_reg_a[c] <= timer_count[c];
        end else if (gra_wr[c]) begin
          general_reg_a[c] <= t16c_merge(general_reg_a[c], acc_i.wdata, acc_i.size);
        end
        if (cap_b[c]) begin
          general_reg_b[c] <= timer_count[c];
        end else if (grb_wr[c]) begin
          general_reg_b[c] <= t16c_merge(general_reg_b[c], acc_i.wdata, acc_i.size);
        end
      end
    end
  end

  // read in state three sees the register before any capture this cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= acc_t3 && !acc_i.write;
      if (acc_t3 && !acc_i.write) begin
        unique case (acc_i.rsel)
          `T16C_SEL_GRA: rd_data_o <= general_reg_a[acc_i.chan];
          `T16C_SEL_GRB: rd_data_o <= general_reg_b[acc_i.chan];
          default: rd_data_o <= timer_count[acc_i.chan];
        endcase
      end
    end
  end

  // flags: a new event beats a clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status <= '0;
      armed <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        logic [2:0] set_c, clr_c;
        set_c = {wrap[c] && !clr[c], cm_b[c] || cap_b[c], cm_a[c] || cap_a[c]};
        clr_c = '0;
        if (flag_acc_i.wr && flag_acc_i.chan == 2'(c)) begin
          clr_c = armed[c] & ~flag_acc_i.wdata;
        end
        status[c] <= (status[c] & ~clr_c) | set_c;
        if (flag_acc_i.rd && flag_acc_i.chan == 2'(c)) begin
          armed[c] <= status[c];
        end else begin
          armed[c] <= armed[c] & ~clr_c;
        end
      end
    end
  end

  // pin: pwm sets on A and resets on B; compare mode toggles on A
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel_a_pin_o <= '0;
      channel_a_pin_oe_o <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        channel_a_pin_oe_o[c] <= cfg_i[c].pwm_mode_bit || !cfg_i[c].io_a_capture_select;
        if (cfg_i[c].pwm_mode_bit) begin
          if (cm_a[c]) begin
            channel_a_pin_o[c] <= 1'b1;
          end else if (cm_b[c]) begin
            channel_a_pin_o[c] <= 1'b0;
          end
        end else if (cm_a[c]) begin
          channel_a_pin_o[c] <= !channel_a_pin_o[c];
        end
      end
    end
  end

  assign timer_count_o = timer_count;
  assign status_o = status;

  // checks sit where the bench drives contention; a match on both sides is a legal corner
  default clocking t16c_cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_clear_beats_write: assert property (clr[0] |=> timer_count[0] == `T16C_ZERO)
    else $error("clear did not win over counter write");
  a_word_write_wins: assert property (cnt_wr[0] && count_pulse_i[0] && !clr[0] &&
      acc_i.size == `T16C_SZ_WORD |=> timer_count[0] == $past(acc_i.wdata))
    else $error("word write lost to increment");
  a_byte_t2_hold: assert property (byte_t2[0] && !clr[0] && !sync_wr |=>
      $stable(timer_count[0]))
    else $error("counter moved during byte write state two");
  a_gr_write_nomatch: assert property (gra_wr[0] && !cap_a[0] &&
      !$rose(status[0][`T16C_FLG_A]) |=> !$rose(status[0][`T16C_FLG_A]))
    else $error("compare match flagged during register write");
  a_ovf_under_write: assert property (cnt_wr[0] && wrap[0] && !clr[0] |=>
      status[0][`T16C_FLG_OVF] && timer_count[0] == $past(sync_val))
    else $error("overflow lost or write not stored");
  a_read_pre_cap: assert property (acc_t3 && !acc_i.write && acc_i.chan == 2'h0 &&
      acc_i.rsel == `T16C_SEL_GRA |=> rd_valid_o && rd_data_o == $past(general_reg_a[0]))
    else $error("read did not return pre-capture value");
  a_cap_clear: assert property (cap_a[0] && cfg_i[0].clear_select == `T16C_CLR_A |=>
      timer_count[0] == `T16C_ZERO && general_reg_a[0] == $past(timer_count[0]))
    else $error("capture clear lost the old count");
  a_cap_over_write: assert property (cap_a[0] && gra_wr[0] |=>
      general_reg_a[0] == $past(timer_count[0]))
    else $error("processor write beat input capture");
  a_sync_preset: assert property (cnt_wr[1] && !clr[1] && !clr[2] &&
      cfg_i[1].sync_enable_ch && cfg_i[2].sync_enable_ch |=>
      timer_count[2] == timer_count[1])
    else $error("synchronized counter not preset");
  a_pwm_set_out: assert property (cfg_i[0].pwm_mode_bit && cm_a[0] |=>
      channel_a_pin_o[0])
    else $error("pwm output not set on match A");
  a_pwm_clr_out: assert property (cfg_i[0].pwm_mode_bit && cm_b[0] |=>
      !channel_a_pin_o[0])
    else $error("pwm output not cleared on match B");
  a_pwm_no_cap: assert property (cfg_i[0].pwm_mode_bit && !gra_wr[0] |=>
      general_reg_a[0] == $past(general_reg_a[0]))
    else $error("capture happened in pwm mode");
  a_wrap_flag: assert property (wrap[0] && !clr[0] |=>
      status[0][`T16C_FLG_OVF])
    else $error("overflow flag not set on wrap");
  a_flag_needs_arm: assert property (flag_acc_i.wr && flag_acc_i.chan == 2'h0 &&
      armed[0] == 3'h0 |=> (status[0] & $past(status[0])) == $past(status[0]))
    else $error("flag cleared without a prior read");

  c_clear_vs_write: cover property (clr[0] && cnt_wr[0]);
  c_byte_t2_inc: cover property (byte_t2[0] && count_pulse_i[0]);
  c_capture_read: cover property (cap_a[0] && acc_t3 && !acc_i.write);
  c_flag_clear: cover property (flag_acc_i.wr && armed[0] != 3'h0);
  c_pwm_both: cover property (cfg_i[0].pwm_mode_bit && count_pulse_i[0] &&
      timer_count[0] == general_reg_a[0] && timer_count[0] == general_reg_b[0]);
endmodule : t16c_timer

// [verilog/t16c_consts.svh]
// constants for the three-channel 16-bit timer contention block
// assumes one 200 MHz clock and bus cycle states reported by the bus master
`ifndef T16C_CONSTS_SVH
`define T16C_CONSTS_SVH
`define T16C_NCH 3
`define T16C_W 16
`define T16C_ZERO 16'h0000
`define T16C_ALL1 16'hffff
`define T16C_ONE 16'h0001
// bus cycle states
`define T16C_T1 2'h1
`define T16C_T2 2'h2
`define T16C_T3 2'h3
// register select codes
`define T16C_SEL_CNT 2'h0
`define T16C_SEL_GRA 2'h1
`define T16C_SEL_GRB 2'h2
// access size codes
`define T16C_SZ_WORD 2'h0
`define T16C_SZ_HIGH 2'h1
`define T16C_SZ_LOW 2'h2
// clear_select codes
`define T16C_CLR_NONE 2'h0
`define T16C_CLR_A 2'h1
`define T16C_CLR_B 2'h2
`define T16C_CLR_SYNC 2'h3
// status bit positions
`define T16C_FLG_A 0
`define T16C_FLG_B 1
`define T16C_FLG_OVF 2
`endif

// [verilog/t16c_pkg.sv]
// types for the three-channel 16-bit timer contention block
// assumes t16c_consts.svh supplies every code and width
`include "t16c_consts.svh"
package t16c_pkg;
  // one processor access, presented for each state of the bus cycle
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] tstate;
    logic [1:0] chan;
    logic [1:0] rsel;
    logic [1:0] size;
    logic [15:0] wdata;
  } t16c_acc_t;
  // per-channel mode settings
  typedef struct packed {
    logic pwm_mode_bit;
    logic io_a_capture_select;
    logic io_b_capture_select;
    logic [1:0] clear_select;
    logic sync_enable_ch;
    logic count_down;
  } t16c_cfg_t;
  // status flag read or write-zero access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] chan;
    logic [2:0] wdata;
  } t16c_flag_acc_t;
endpackage : t16c_pkg

// [tb/t16c_bus_model.sv]
// processor bus master model: three-state register cycles and status flag accesses
// assumes one clock shared with the timer; the bench calls its tasks
`include "t16c_consts.svh"
module t16c_bus_model (
  input wire logic clk_i,
  output t16c_pkg::t16c_acc_t acc_o,
  output t16c_pkg::t16c_flag_acc_t flag_acc_o,
  input wire logic [15:0] rd_data_i,
  input wire logic rd_valid_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    acc_o = '0;
    flag_acc_o = '0;
  end
  // one access, T1 to T3, every field held until the T3 edge has passed
  task automatic cyc(input logic wr, input logic [1:0] ch, input logic [1:0] rs,
      input logic [1:0] sz, input logic [15:0] d);
    @(posedge clk_i);
    acc_o <= '{1'b1, wr, `T16C_T1, ch, rs, sz, d};
    @(posedge clk_i);
    acc_o.tstate <= `T16C_T2;
    @(posedge clk_i);
    acc_o.tstate <= `T16C_T3;
    @(posedge clk_i);
    // released data lines must not keep showing the old value
    acc_o <= '{1'b0, 1'b0, 2'h0, ch, rs, sz, ~d};
  endtask : cyc
  // read: data is taken at the edge where the valid pulse is seen
  task automatic rd(input logic [1:0] ch, input logic [1:0] rs, output logic [15:0] q);
    cyc(1'b0, ch, rs, `T16C_SZ_WORD, 16'h0000);
    @(posedge clk_i);
    q = rd_valid_i ? rd_data_i : 16'hdead;
  endtask : rd
  // status access pulse; a clear only works after a read while the bit was set
  task automatic flag(input logic r, input logic w, input logic [1:0] ch, input logic [2:0] d);
    @(posedge clk_i);
    flag_acc_o <= '{r, w, ch, d};
    @(posedge clk_i);
    flag_acc_o <= '{1'b0, 1'b0, ch, ~d};
  endtask : flag
endmodule : t16c_bus_model

// [tb/t16c_timer_tb_top.sv]
// bench top: drives the timer through the bus model and checks contention cases
// assumes the design files and t16c_consts.svh are compiled first
`include "t16c_consts.svh"
module t16c_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  t16c_pkg::t16c_acc_t acc;
  t16c_pkg::t16c_flag_acc_t facc;
  t16c_pkg::t16c_cfg_t [2:0] cfg = '0;
  logic [2:0] pulse = '0;
  logic [2:0] cap_a = '0;
  logic [2:0] cap_b = '0;
  logic [2:0][15:0] cnt;
  logic [2:0][2:0] st;
  logic [15:0] rdd;
  logic [15:0] q;
  logic rdv;
  logic [2:0] pin;
  logic [2:0] oe;
  int failures = 0;
  int samples_checked = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  t16c_timer t16c_timer_inst (.clk_i(clk), .rst_n_i(rst_n), .acc_i(acc), .flag_acc_i(facc),
    .cfg_i(cfg), .count_pulse_i(pulse), .capture_a_pin_i(cap_a), .capture_b_pin_i(cap_b),
    .timer_count_o(cnt), .status_o(st), .rd_data_o(rdd), .rd_valid_o(rdv),
    .channel_a_pin_o(pin), .channel_a_pin_oe_o(oe));
  t16c_bus_model t16c_bus_model_inst (.clk_i(clk), .acc_o(acc), .flag_acc_o(facc),
    .rd_data_i(rdd), .rd_valid_i(rdv));
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  // writes settle before any check, so checks wait for the falling edge
  task automatic w(input logic [1:0] ch, input logic [1:0] rs, input logic [1:0] sz,
      input logic [15:0] d);
    t16c_bus_model_inst.cyc(1'b1, ch, rs, sz, d);
    @(negedge clk);
  endtask : w
  task automatic wc(input logic [1:0] ch, input logic [15:0] d);
    w(ch, `T16C_SEL_CNT, `T16C_SZ_WORD, d);
  endtask : wc
  // pulse after k edges: k=2 meets T2, k=3 meets T3 of a write started alongside
  task automatic pls(input logic [2:0] m, input int k);
    repeat (k) @(posedge clk);
    pulse <= m;
    @(posedge clk);
    pulse <= 3'h0;
  endtask : pls
  task automatic cnt_up(input logic [2:0] m, input int n);
    repeat (n) pls(m, 1);
    @(negedge clk);
  endtask : cnt_up
  task automatic flg(input logic r, input logic wr, input logic [1:0] ch);
    t16c_bus_model_inst.flag(r, wr, ch, 3'h0);
    @(negedge clk);
  endtask : flg
  task automatic clr(input logic [1:0] ch);
    flg(1'b1, 1'b0, ch);
    flg(1'b0, 1'b1, ch);
  endtask : clr
  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    chk("cnt_rst", cnt[0], 16'h0000);
    rst_n <= 1'b1;
    wc(0, 16'h1234);
    chk("plain", cnt[0], 16'h1234);
    fork
      wc(0, 16'h2222);
      pls(3'h1, 3);
    join
    chk("word_inc", cnt[0], 16'h2222);
    fork
      w(0, `T16C_SEL_CNT, `T16C_SZ_HIGH, 16'habab);
      pls(3'h1, 2);
    join
    chk("byte_inc", cnt[0], 16'hab22);
    wc(0, 16'hffff);
    fork
      wc(0, 16'h0100);
      pls(3'h1, 3);
    join
    chk("ovf_wr", cnt[0], 16'h0100);
    // general registers still hold ffff, so both compare flags rise with the wrap
    chk("ovf_flag", {13'h0, st[0]}, 16'h0007);
    flg(1'b0, 1'b1, 0);
    chk("clr_noread", {13'h0, st[0]}, 16'h0007);
    clr(0);
    chk("clr_ok", {13'h0, st[0]}, 16'h0000);
    @(posedge clk);
    cfg[0].count_down <= 1'b1;
    wc(0, 16'h0000);
    cnt_up(3'h1, 1);
    chk("under", cnt[0], 16'hffff);
    chk("under_flag", {13'h0, st[0]}, 16'h0004);
    @(posedge clk);
    cfg[0].count_down <= 1'b0;
    // clear on source A, then on source B: period is N plus one pulses
    for (int i = 1; i < 3; i++) begin
      clr(0);
      @(posedge clk);
      cfg[0].clear_select <= 2'(i);
      w(0, 2'(i), `T16C_SZ_WORD, 16'h0002);
      wc(0, 16'h0000);
      cnt_up(3'h1, 2);
      chk("below_n", cnt[0], 16'h0002);
      cnt_up(3'h1, 1);
      chk("period", cnt[0], 16'h0000);
      chk("match_flag", {15'h0, st[0][i-1]}, 16'h0001);
    end
    wc(0, 16'h0002);
    fork
      wc(0, 16'h0055);
      pls(3'h1, 3);
    join
    chk("clr_wins", cnt[0], 16'h0000);
    @(posedge clk);
    cfg[0].clear_select <= `T16C_CLR_NONE;
    clr(0);
    wc(0, 16'h0002);
    fork
      w(0, `T16C_SEL_GRB, `T16C_SZ_WORD, 16'h0010);
      pls(3'h1, 3);
    join
    chk("gr_wr_match", {15'h0, st[0][1]}, 16'h0000);
    chk("count_on", cnt[0], 16'h0003);
    // synchronized preset and synchronized clear
    @(posedge clk);
    cfg[1].sync_enable_ch <= 1'b1;
    cfg[2].sync_enable_ch <= 1'b1;
    cfg[1].clear_select <= `T16C_CLR_A;
    cfg[2].clear_select <= `T16C_CLR_SYNC;
    wc(2, 16'h1111);
    w(1, `T16C_SEL_CNT, `T16C_SZ_LOW, 16'hcdcd);
    chk("sync_pre", cnt[2], 16'h11cd);
    w(1, `T16C_SEL_GRA, `T16C_SZ_WORD, 16'h11cf);
    cnt_up(3'h6, 3);
    chk("sync_clr", cnt[2], 16'h0000);
    // PWM on channel 0
    @(posedge clk);
    cfg[0].pwm_mode_bit <= 1'b1;
    w(0, `T16C_SEL_GRA, `T16C_SZ_WORD, 16'h0002);
    w(0, `T16C_SEL_GRB, `T16C_SZ_WORD, 16'h0004);
    // earlier toggles left the pin high, so bring it low first
    wc(0, 16'h0003);
    cnt_up(3'h1, 2);
    chk("pwm_lo0", {15'h0, pin[0]}, 16'h0000);
    wc(0, 16'h0000);
    cnt_up(3'h1, 3);
    chk("pwm_hi", {15'h0, pin[0]}, 16'h0001);
    cnt_up(3'h1, 2);
    chk("pwm_lo", {15'h0, pin[0]}, 16'h0000);
    w(0, `T16C_SEL_GRA, `T16C_SZ_WORD, 16'h0006);
    w(0, `T16C_SEL_GRB, `T16C_SZ_WORD, 16'h0006);
    cnt_up(3'h1, 2);
    chk("pwm_both", {15'h0, pin[0]}, 16'h0000);
    chk("pwm_oe", {15'h0, oe[0]}, 16'h0001);
    // channel 0 capture lands in T3 of a register write, then of a read
    @(posedge clk);
    cfg[0].pwm_mode_bit <= 1'b0;
    cfg[0].io_a_capture_select <= 1'b1;
    cfg[0].clear_select <= `T16C_CLR_A;
    wc(0, 16'h0040);
    fork
      w(0, `T16C_SEL_GRA, `T16C_SZ_WORD, 16'h5555);
      pls(3'h1, 3);
      begin
        @(posedge clk);
        cap_a[0] <= 1'b1;
      end
    join
    chk("cap_clr", cnt[0], 16'h0000);
    wc(0, 16'h0077);
    @(posedge clk);
    cap_a[0] <= 1'b0;
    fork
      t16c_bus_model_inst.rd(0, `T16C_SEL_GRA, q);
      begin
        @(posedge clk);
        cap_a[0] <= 1'b1;
      end
    join
    chk("rd_pre_cap", q, 16'h0040);
    t16c_bus_model_inst.rd(0, `T16C_SEL_GRA, q);
    chk("cap_old_cnt", q, 16'h0077);
    chk("cap_a_clr", cnt[0], 16'h0000);
    // capture on channel 2, then refused once PWM is on
    @(posedge clk);
    cfg[1].sync_enable_ch <= 1'b0;
    cfg[2].sync_enable_ch <= 1'b0;
    cfg[2].clear_select <= `T16C_CLR_NONE;
    cfg[2].io_a_capture_select <= 1'b1;
    cfg[2].io_b_capture_select <= 1'b1;
    wc(2, 16'h0abc);
    @(posedge clk);
    cap_a[2] <= 1'b1;
    cap_b[2] <= 1'b1;
    repeat (8) @(posedge clk);
    t16c_bus_model_inst.rd(2, `T16C_SEL_GRA, q);
    chk("capture", q, 16'h0abc);
    t16c_bus_model_inst.rd(2, `T16C_SEL_GRB, q);
    chk("capture_b", q, 16'h0abc);
    chk("cap_oe", {15'h0, oe[2]}, 16'h0000);
    cap_a[2] <= 1'b0;
    cap_b[2] <= 1'b0;
    cfg[2].pwm_mode_bit <= 1'b1;
    wc(2, 16'h0def);
    @(posedge clk);
    cap_a[2] <= 1'b1;
    cap_b[2] <= 1'b1;
    repeat (8) @(posedge clk);
    t16c_bus_model_inst.rd(2, `T16C_SEL_GRA, q);
    chk("pwm_nocap", q, 16'h0abc);
    t16c_bus_model_inst.rd(2, `T16C_SEL_GRB, q);
    chk("pwm_nocap_b", q, 16'h0abc);
    end_of_test();
  end
endmodule : t16c_timer_tb_top
